// ---- src/umad_consts.svh ----
// address map constants for the upper memory address decoder
`ifndef UMAD_CONSTS_SVH
`define UMAD_CONSTS_SVH

// ============================================================
// widths
`define UMAD_ADDR_W 32
`define UMAD_MB_W 12
`define UMAD_MB_LSB 20
`define UMAD_PAGE_LSB 12
`define UMAD_FRAME_W 20
`define UMAD_IO_W 16
`define UMAD_IO_WIN_LSB 12
`define UMAD_IO_WIN_W 4

// ============================================================
// fixed regions, as address bits 31:20
`define UMAD_APIC_IO_MB 12'hFEC
`define UMAD_APIC_LOCAL_MB 12'hFEE
`define UMAD_GAP_LO_MB 12'hFED
`define UMAD_GAP_HI_MB 12'hFFD
`define UMAD_BIOS_LO_MB 12'hFFE
`define UMAD_APIC_UNIT_LSB 12
`define UMAD_APIC_UNIT_W 4
`define UMAD_APIC_UNIT_SPAN_LSB 16

// ============================================================
// programmable windows
`define UMAD_APER_LSB 22
`define UMAD_APER_W 10
`define UMAD_IMPCOMP_LSB 12
`define UMAD_GFX_CFG_LSB 19
`define UMAD_CMD_IO_EN_BIT 0
`define UMAD_CMD_MEM_EN_BIT 1
`define UMAD_CMD_W 16
`define UMAD_TT_IDX_W 10

// ============================================================
// configuration i/o ports, compared on bits 15:2
`define UMAD_CFG_ADDR_PORT 14'h033E
`define UMAD_CFG_DATA_PORT 14'h033F
`define UMAD_CFG_PORT_LSB 2

`endif

// ---- src/umad_pkg.sv ----
// types shared by the upper memory address decoder
`include "umad_consts.svh"

package umad_pkg;

	typedef enum logic [1:0] {
		UMAD_INIT_FSB,
		UMAD_INIT_HUB,
		UMAD_INIT_AGP_PCI,
		UMAD_INIT_AGP
	} umad_init_e;

	typedef enum logic [2:0] {
		UMAD_TGT_HUB,
		UMAD_TGT_DRAM,
		UMAD_TGT_PORT,
		UMAD_TGT_GFX,
		UMAD_TGT_CFG,
		UMAD_TGT_IMPCOMP
	} umad_tgt_e;

	typedef struct packed {
		logic [`UMAD_ADDR_W-1:0] addr;
		logic is_io;
		umad_init_e initiator;
		logic cacheable;
	} umad_req_s;

	typedef struct packed {
		umad_tgt_e target;
		logic [`UMAD_ADDR_W-1:0] addr;
		logic snoop;
		logic translated;
		logic xlate_fault;
		logic apic_hit;
		logic [`UMAD_APIC_UNIT_W-1:0] apic_unit;
	} umad_resp_s;

	typedef struct packed {
		logic [`UMAD_MB_W-1:0] base;
		logic [`UMAD_MB_W-1:0] limit;
	} umad_win_s;

	typedef struct packed {
		logic valid;
		logic [`UMAD_FRAME_W-1:0] frame;
	} umad_tt_entry_s;

endpackage

// ---- src/umad_window_match.sv ----
// inclusive base/limit window compare on upper address bits
`timescale 1ns/100ps
`default_nettype none

module umad_window_match #(
	parameter int W = 12
) (
	input wire logic enable_in,
	input wire logic [W-1:0] base_in,
	input wire logic [W-1:0] limit_in,
	input wire logic [W-1:0] addr_hi_in,
	output logic hit_out
);

	// low bits are implied zero for base and all ones for limit, so
	// comparing only the upper bits gives aligned granular windows
	wire logic ge_base = addr_hi_in >= base_in;
	wire logic le_limit = addr_hi_in <= limit_in;

	assign hit_out = enable_in && ge_base && le_limit;

endmodule // umad_window_match

`default_nettype wire

// ---- src/umad_xlate_mem.sv ----
// aperture translation table, one entry per 4 KB page
`timescale 1ns/100ps
`default_nettype none

module umad_xlate_mem
	import umad_pkg::*;
#(
	parameter int IDX_W = `UMAD_TT_IDX_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [IDX_W-1:0] wr_idx_in,
	input wire umad_tt_entry_s wr_entry_in,
	input wire logic rd_en_in,
	input wire logic [IDX_W-1:0] rd_idx_in,
	output umad_tt_entry_s rd_entry_out
);

	umad_tt_entry_s mem_q [2**IDX_W];
	umad_tt_entry_s rd_q;

	// array has no reset so it maps onto block ram
	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_idx_in] <= wr_entry_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rd_q <= '0;
		end else if (rd_en_in) begin
			rd_q <= mem_q[rd_idx_in];
		end
	end

	assign rd_entry_out = rd_q;

endmodule // umad_xlate_mem

`default_nettype wire

// ---- src/umad_decoder.sv ----
// upper memory and host i/o address decoder with aperture translation
`timescale 1ns/100ps
`default_nettype none
`include "umad_consts.svh"

// Functional notes
// R1: unclaimed space above memory goes to hub
// R2: compensation register window claimed internally
// R3: graphics config and memory go to graphics
// R4: port windows route to the port
// R5: aperture hits go to main memory
// R6: aperture addresses translated through table
// R7: software keeps windows off fixed regions
// R8: apic regions forwarded to hub
// R9: apic never routed to the port
// R10: gap before high bios goes to hub
// R11: top 2 MB bios goes to hub
// R12: window bits compared against A[31:20]
// R13: base low bits zero, limit ones
// R14: inclusive base and limit compare
// R15: memory enable bit gates port windows
// R16: io and memory cycles have own targets
// R17: full 32-bit host address decoded
// R18: snoop rules by initiator and cacheability
// R19: fixed and internal claims beat port windows
module umad_decoder
	import umad_pkg::*;
#(
	parameter int TT_IDX_W = `UMAD_TT_IDX_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire umad_req_s req_in,
	input wire logic mch_mode_in,
	input wire logic gfx_active_in,
	input wire logic port_active_in,
	input wire logic [`UMAD_MB_W-1:0] top_of_usable_memory_in,
	input wire logic [`UMAD_ADDR_W-1:`UMAD_IMPCOMP_LSB] impedance_compensation_base_in,
	input wire logic [`UMAD_ADDR_W-1:`UMAD_GFX_CFG_LSB] gfx_cfg_base_in,
	input wire umad_win_s gfx_mem_window_in,
	input wire umad_win_s port_window_in,
	input wire umad_win_s prefetch_window_in,
	input wire logic [`UMAD_IO_WIN_W-1:0] port_io_base_in,
	input wire logic [`UMAD_IO_WIN_W-1:0] port_io_limit_in,
	input wire logic [`UMAD_CMD_W-1:0] port_command_setting_in,
	input wire logic [`UMAD_APER_W-1:0] aperture_base_in,
	input wire logic [`UMAD_APER_W-1:0] aperture_size_in,
	input wire logic tt_wr_en_in,
	input wire logic [TT_IDX_W-1:0] tt_wr_idx_in,
	input wire umad_tt_entry_s tt_wr_entry_in,
	output logic resp_valid_out,
	output umad_resp_s resp_out
);

	// ============================================================
	// address fields
	wire logic [`UMAD_ADDR_W-1:0] addr = req_in.addr;
	// R17: full address used
	wire logic [`UMAD_MB_W-1:0] addr_mb = addr[`UMAD_ADDR_W-1:`UMAD_MB_LSB];
	// io cycles carry their port address in the low sixteen bits
	wire logic [`UMAD_IO_W-1:0] io_addr = addr[`UMAD_IO_W-1:0];
	wire logic mem_en = port_command_setting_in[`UMAD_CMD_MEM_EN_BIT];
	wire logic io_en = port_command_setting_in[`UMAD_CMD_IO_EN_BIT];
	wire logic mem_cycle = !req_in.is_io;

	// ============================================================
	// fixed regions
	// R8: apic ranges
	wire logic apic_io_hit = addr_mb == `UMAD_APIC_IO_MB;
	wire logic apic_local_hit = addr_mb == `UMAD_APIC_LOCAL_MB;
	wire logic apic_hit = apic_io_hit || apic_local_hit;
	// R10: gap to hub when above top of memory
	wire logic gap_range = (addr_mb >= `UMAD_GAP_LO_MB) && (addr_mb <= `UMAD_GAP_HI_MB);
	wire logic gap_hit = gap_range && !apic_local_hit;
	// R11: top 2 MB bios
	wire logic bios_hit = addr_mb >= `UMAD_BIOS_LO_MB;
	// fixed ranges only win above top of memory: top must stay below the apic
	// space, or the apic units would be handed to dram
	wire logic fixed_hit = apic_hit || gap_hit || bios_hit;
	// i/o apic unit x sits at FEC0_x000; only the first 64 KB holds units
	wire logic unit_span = addr[`UMAD_MB_LSB-1:`UMAD_APIC_UNIT_SPAN_LSB] == '0;
	wire logic apic_unit_hit = apic_io_hit && unit_span;
	wire logic [`UMAD_APIC_UNIT_W-1:0] apic_unit =
		addr[`UMAD_APIC_UNIT_LSB+`UMAD_APIC_UNIT_W-1:`UMAD_APIC_UNIT_LSB];

	// ============================================================
	// internal claims
	// R2: compensation window
	wire logic [`UMAD_ADDR_W-1:`UMAD_IMPCOMP_LSB] impcomp_page = addr[`UMAD_ADDR_W-1:`UMAD_IMPCOMP_LSB];
	wire logic impcomp_match = impcomp_page == impedance_compensation_base_in;
	wire logic impcomp_hit = mch_mode_in && impcomp_match;
	// R3: graphics config registers
	wire logic [`UMAD_ADDR_W-1:`UMAD_GFX_CFG_LSB] gfx_cfg_block = addr[`UMAD_ADDR_W-1:`UMAD_GFX_CFG_LSB];
	wire logic gfx_cfg_match = gfx_cfg_block == gfx_cfg_base_in;
	wire logic gfx_cfg_hit = gfx_active_in && gfx_cfg_match;
	wire logic gfx_mem_hit;

	// R3: graphics memory window
	umad_window_match #(.W(`UMAD_MB_W)) u_gfx_win (
		.enable_in(gfx_active_in),
		.base_in(gfx_mem_window_in.base),
		.limit_in(gfx_mem_window_in.limit),
		.addr_hi_in(addr_mb),
		.hit_out(gfx_mem_hit)
	);
	wire logic gfx_hit = gfx_cfg_hit || gfx_mem_hit;

	// ============================================================
	// main memory and aperture
	wire logic above_top = addr_mb >= top_of_usable_memory_in;
	wire logic [`UMAD_APER_W-1:0] aper_bits = addr[`UMAD_ADDR_W-1:`UMAD_APER_LSB];
	wire logic [`UMAD_APER_W-1:0] aper_diff = aper_bits ^ aperture_base_in;
	// R5: size is a mask of compared bits
	// a mask keeps the aperture naturally aligned at no adder cost
	wire logic [`UMAD_APER_W-1:0] aper_masked = aper_diff & aperture_size_in;
	wire logic aper_hit = port_active_in && (aper_masked == '0);

	// ============================================================
	// port memory windows
	// the prefetchable window decodes like the plain one; the split only lets
	// the processor write-combine into it
	umad_win_s port_win [2];
	logic [1:0] port_win_hit;
	wire logic port_mem_en = port_active_in && mem_en;
	assign port_win[0] = port_window_in;
	assign port_win[1] = prefetch_window_in;

	// R4: both windows decoded alike
	for (genvar i = 0; i < 2; i++) begin : g_port_win
		// R12: upper bits compare
		// R13: implied low bits
		// R14: inclusive bounds
		// R15: gated by memory enable
		umad_window_match #(.W(`UMAD_MB_W)) u_win (
			.enable_in(port_mem_en),
			.base_in(port_win[i].base),
			.limit_in(port_win[i].limit),
			.addr_hi_in(addr_mb),
			.hit_out(port_win_hit[i])
		);
	end
	wire logic port_mem_hit = |port_win_hit;

	// ============================================================
	// memory target priority
	// R19: memory, fixed, internal, aperture, windows, hub
	// each claim is masked by all claims above it, so exactly one is set and a
	// window overlapping a fixed region loses with no further logic
	wire logic claim_low = !above_top;
	// R9: apic checked before windows
	wire logic claim_fixed = above_top && fixed_hit;
	wire logic open_fixed = above_top && !fixed_hit;
	wire logic claim_impcomp = open_fixed && impcomp_hit;
	wire logic open_impcomp = open_fixed && !impcomp_hit;
	wire logic claim_gfx = open_impcomp && gfx_hit;
	wire logic open_gfx = open_impcomp && !gfx_hit;
	wire logic claim_aper = open_gfx && aper_hit;
	wire logic open_aper = open_gfx && !aper_hit;
	wire logic claim_port = open_aper && port_mem_hit;
	// R1: default to hub
	wire logic claim_hub = open_aper && !port_mem_hit;
	wire logic to_hub = claim_fixed || claim_hub;
	wire logic to_dram = claim_low || claim_aper;
	umad_tgt_e mem_tgt;
	assign mem_tgt =
		to_hub ? UMAD_TGT_HUB :
		to_dram ? UMAD_TGT_DRAM :
		claim_impcomp ? UMAD_TGT_IMPCOMP :
		claim_gfx ? UMAD_TGT_GFX :
		claim_port ? UMAD_TGT_PORT :
		UMAD_TGT_HUB;
	wire logic mem_aper = claim_aper;

	// ============================================================
	// host i/o decode
	wire logic [`UMAD_IO_W-1:`UMAD_CFG_PORT_LSB] io_dw = io_addr[`UMAD_IO_W-1:`UMAD_CFG_PORT_LSB];
	// the configuration ports are claimed whatever the window settings
	wire logic io_cfg_addr_hit = io_dw == `UMAD_CFG_ADDR_PORT;
	wire logic io_cfg_data_hit = io_dw == `UMAD_CFG_DATA_PORT;
	wire logic io_cfg_hit = io_cfg_addr_hit || io_cfg_data_hit;
	// io window is 4 KB granular, so only io address bits 15:12 are compared
	wire logic io_win_en = port_active_in && io_en;
	wire logic [`UMAD_IO_WIN_W-1:0] io_hi = io_addr[`UMAD_IO_W-1:`UMAD_IO_WIN_LSB];
	logic io_port_hit;
	umad_window_match #(.W(`UMAD_IO_WIN_W)) u_io_win (
		.enable_in(io_win_en),
		.base_in(port_io_base_in),
		.limit_in(port_io_limit_in),
		.addr_hi_in(io_hi),
		.hit_out(io_port_hit)
	);
	// R16: io targets
	umad_tgt_e io_tgt;
	assign io_tgt =
		io_cfg_hit ? UMAD_TGT_CFG :
		io_port_hit ? UMAD_TGT_PORT :
		UMAD_TGT_HUB;

	// R16: memory versus io selection
	umad_tgt_e sel_tgt;
	assign sel_tgt = req_in.is_io ? io_tgt : mem_tgt;
	wire logic sel_aper = mem_cycle && mem_aper;

	// ============================================================
	// snoop policy
	// R18: agp non-cacheable not snooped
	// processor cycles are never snooped back onto the bus they came from
	wire logic from_hub = req_in.initiator == UMAD_INIT_HUB;
	wire logic from_agp_pci = req_in.initiator == UMAD_INIT_AGP_PCI;
	wire logic from_agp_cached = (req_in.initiator == UMAD_INIT_AGP) && req_in.cacheable;
	wire logic init_snoops = from_hub || from_agp_pci || from_agp_cached;
	wire logic sel_snoop = (sel_tgt == UMAD_TGT_DRAM) && init_snoops;

	// ============================================================
	// translation table, read launched with the decode
	umad_tt_entry_s tt_entry;
	// the table holds 2**TT_IDX_W pages; a larger aperture aliases onto it
	wire logic [TT_IDX_W-1:0] tt_rd_idx = addr[`UMAD_PAGE_LSB+TT_IDX_W-1:`UMAD_PAGE_LSB];
	wire logic tt_rd_en = req_valid_in && sel_aper;

	// R6: table looked up on aperture hit
	umad_xlate_mem #(.IDX_W(TT_IDX_W)) u_tt (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(tt_wr_en_in),
		.wr_idx_in(tt_wr_idx_in),
		.wr_entry_in(tt_wr_entry_in),
		.rd_en_in(tt_rd_en),
		.rd_idx_in(tt_rd_idx),
		.rd_entry_out(tt_entry)
	);

	// ============================================================
	// stage one: decoded request
	// decode lands here while the table read is in flight, so every answer
	// comes exactly two cycles after its request, translated or not
	// R8: only memory cycles reach the apic units
	wire logic s1_apic = mem_cycle && apic_unit_hit;
	umad_resp_s s1_d;
	umad_resp_s s1_q;
	logic s1_valid_q;

	always_comb begin
		s1_d = '0;
		s1_d.target = sel_tgt;
		s1_d.addr = addr;
		s1_d.snoop = sel_snoop;
		s1_d.translated = sel_aper;
		s1_d.apic_hit = s1_apic;
		s1_d.apic_unit = apic_unit;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s1_valid_q <= 1'b0;
			s1_q <= '0;
		end else begin
			s1_valid_q <= req_valid_in;
			s1_q <= s1_d;
		end
	end

	// ============================================================
	// stage two: translated answer
	// R6: frame replaces page number
	// the table read runs alongside stage one, so the frame meets its own request
	wire logic [`UMAD_FRAME_W-1:0] tt_frame = tt_entry.frame;
	wire logic [`UMAD_PAGE_LSB-1:0] page_off = s1_q.addr[`UMAD_PAGE_LSB-1:0];
	wire logic tt_fault = !tt_entry.valid;
	wire logic [`UMAD_ADDR_W-1:0] xlate_addr = {tt_frame, page_off};
	umad_resp_s resp_d;
	umad_resp_s resp_q;
	logic resp_valid_q;

	// an invalid entry still goes to dram but is flagged for the requester
	always_comb begin
		resp_d = s1_q;
		if (s1_q.translated) begin
			resp_d.addr = xlate_addr;
			resp_d.xlate_fault = tt_fault;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			resp_valid_q <= 1'b0;
			resp_q <= '0;
		end else begin
			resp_valid_q <= s1_valid_q;
			resp_q <= resp_d;
		end
	end

	assign resp_valid_out = resp_valid_q;
	assign resp_out = resp_q;

endmodule // umad_decoder

`default_nettype wire

// ---- dv/umad_decoder_checker.sv ----
// assertion checker for the upper memory address decoder
`timescale 1ns/100ps
`default_nettype none
`include "umad_consts.svh"

module umad_decoder_checker
	import umad_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire umad_req_s req_in,
	input wire logic [`UMAD_MB_W-1:0] top_of_usable_memory_in,
	input wire logic [`UMAD_CMD_W-1:0] port_command_setting_in,
	input wire logic resp_valid_out,
	input wire umad_resp_s resp_out
);
	// ============================================================
	// helpers
	wire logic [11:0] mb = req_in.addr[31:20];
	wire logic mreq = req_valid_in && !req_in.is_io;
	wire logic up = mreq && mb >= top_of_usable_memory_in;
	wire umad_tgt_e tgt = resp_out.target;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// ============================================================
	// assertions
	resp_lat_a: assert property (req_valid_in |-> ##2 resp_valid_out) else $error("answer late");
	no_spur_a: assert property (resp_valid_out |-> $past(req_valid_in, 2)) else $error("stray answer");
	below_top_a: assert property (mreq && mb < top_of_usable_memory_in |-> ##2 tgt == UMAD_TGT_DRAM)
		else $error("main memory miss");
	apic_hub_a: assert property (up && (mb == `UMAD_APIC_IO_MB || mb == `UMAD_APIC_LOCAL_MB)
		|-> ##2 tgt == UMAD_TGT_HUB) else $error("apic not to hub");
	gap_hub_a: assert property (up && mb >= `UMAD_GAP_LO_MB && mb <= `UMAD_GAP_HI_MB
		|-> ##2 tgt == UMAD_TGT_HUB) else $error("gap not to hub");
	bios_hub_a: assert property (up && mb >= `UMAD_BIOS_LO_MB |-> ##2 tgt == UMAD_TGT_HUB)
		else $error("bios not to hub");
	mem_en_a: assert property (mreq && !port_command_setting_in[1] |-> ##2 tgt != UMAD_TGT_PORT)
		else $error("port window while off");
	apic_unit_a: assert property (mreq && req_in.addr[31:16] == 16'hFEC0
		|-> ##2 resp_out.apic_hit && resp_out.apic_unit == $past(req_in.addr[15:12], 2))
		else $error("apic unit wrong");
	snoop_a: assert property (resp_valid_out |-> resp_out.snoop == (tgt == UMAD_TGT_DRAM
		&& $past(req_in.initiator, 2) != UMAD_INIT_FSB
		&& ($past(req_in.initiator, 2) != UMAD_INIT_AGP || $past(req_in.cacheable, 2))))
		else $error("snoop wrong");
	xlate_a: assert property (resp_valid_out && resp_out.translated |-> tgt == UMAD_TGT_DRAM)
		else $error("translated off memory");
endmodule // umad_decoder_checker

bind umad_decoder umad_decoder_checker i_umad_decoder_checker (.clk_in, .rst_n_in, .req_valid_in,
	.req_in, .top_of_usable_memory_in, .port_command_setting_in, .resp_valid_out, .resp_out);
`default_nettype wire

// ---- dv/umad_host_model.sv ----
// host bus initiator model feeding the decoder
`timescale 1ns/100ps
`default_nettype none

module umad_host_model
	import umad_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic issue_in,
	input wire umad_req_s cmd_in,
	output logic req_valid_out,
	output umad_req_s req_out
);
	// ============================================================
	// launch
	// full address width
	// idle cycles flip the fields so stale values are never mistaken for a request
	always_ff @(posedge clk_in) begin
		req_valid_out <= rst_n_in && issue_in;
		if (!rst_n_in) begin
			req_out <= '0;
		end else if (issue_in) begin
			req_out <= cmd_in;
		end else begin
			req_out <= umad_req_s'(~req_out);
		end
	end
endmodule // umad_host_model
`default_nettype wire

// ---- dv/test_umad_decoder.sv ----
// self-checking testbench for the upper memory address decoder
`timescale 1ns/100ps
`default_nettype none
`include "umad_consts.svh"

module test_umad_decoder
	import umad_pkg::*;
;
	// ============================================================
	// stimulus state
	logic clk_in = 1'b0, rst_n_in = 1'b0, issue = 1'b0, req_valid_in, resp_valid_out;
	umad_req_s cmd = '0, req_in;
	umad_resp_s resp_out;
	logic mch_mode_in = 1'b1, gfx_active_in = 1'b1, port_active_in = 1'b1;
	logic [11:0] top_of_usable_memory_in = 12'h400;
	logic [31:12] impedance_compensation_base_in = 20'hB0000;
	logic [31:19] gfx_cfg_base_in = 13'h1C00;
	umad_win_s gfx_mem_window_in = '{12'hA00, 12'hA0F}, port_window_in = '{12'h800, 12'h80F};
	umad_win_s prefetch_window_in = '{12'h900, 12'h93F};
	logic [3:0] port_io_base_in = 4'h1, port_io_limit_in = 4'h2;
	logic [15:0] port_command_setting_in = 16'h0003;
	logic [9:0] aperture_base_in = 10'h300, aperture_size_in = 10'h3FF, tt_wr_idx_in = '0;
	logic tt_wr_en_in = 1'b0;
	umad_tt_entry_s tt_wr_entry_in = '0, tt[1024];
	logic [42:0] expq[$];
	logic [42:0] exp_now;
	int errors = 0, checks_done = 0;
	logic [11:0] mbs[24] = '{12'h3FF, 12'h400, 12'h7FF, 12'h800, 12'h80F, 12'h810, 12'h8FF, 12'h900,
		12'h93F, 12'h940, 12'hA00, 12'hA0F, 12'hB00, 12'hC00, 12'hC03, 12'hC04, 12'hE00, 12'hFEC,
		12'hFED, 12'hFEE, 12'hFEF, 12'hFFD, 12'hFFE, 12'hFFF};
	logic [15:0] ios[7] = '{16'h0CF8, 16'h0CFC, 16'h0CF4, 16'h1000, 16'h2FFF, 16'h3000, 16'h0FFF};

	always #4 clk_in = ~clk_in;

	umad_host_model i_umad_host_model (.clk_in, .rst_n_in, .issue_in(issue), .cmd_in(cmd),
		.req_valid_out(req_valid_in), .req_out(req_in));
	umad_decoder i_umad_decoder (.clk_in, .rst_n_in, .req_valid_in, .req_in, .mch_mode_in,
		.gfx_active_in, .port_active_in, .top_of_usable_memory_in, .impedance_compensation_base_in,
		.gfx_cfg_base_in, .gfx_mem_window_in, .port_window_in, .prefetch_window_in, .port_io_base_in,
		.port_io_limit_in, .port_command_setting_in, .aperture_base_in, .aperture_size_in,
		.tt_wr_en_in, .tt_wr_idx_in, .tt_wr_entry_in, .resp_valid_out, .resp_out);

	// ============================================================
	// expectation, first match wins
	function automatic logic [42:0] expect_of(umad_req_s r);
		logic [11:0] mb;
		umad_tgt_e t;
		logic [31:0] a;
		logic f;
		logic s;
		logic x;
		logic h;
		mb = r.addr[31:20];
		a = r.addr;
		f = 1'b0;
		x = 1'b0;
		h = !r.is_io && r.addr[31:16] == 16'hFEC0;
		t = UMAD_TGT_HUB;
		if (r.is_io) begin
			if (r.addr[15:2] == `UMAD_CFG_ADDR_PORT || r.addr[15:2] == `UMAD_CFG_DATA_PORT) t = UMAD_TGT_CFG;
			else if (port_active_in && port_command_setting_in[0] && r.addr[15:12] >= port_io_base_in
				&& r.addr[15:12] <= port_io_limit_in) t = UMAD_TGT_PORT;
		end else if (mb < top_of_usable_memory_in) t = UMAD_TGT_DRAM;
		else if (mb >= `UMAD_APIC_IO_MB) t = UMAD_TGT_HUB;
		else if (mch_mode_in && r.addr[31:12] == impedance_compensation_base_in) t = UMAD_TGT_IMPCOMP;
		else if (gfx_active_in && (r.addr[31:19] == gfx_cfg_base_in
			|| (mb >= gfx_mem_window_in.base && mb <= gfx_mem_window_in.limit))) t = UMAD_TGT_GFX;
		else if (port_active_in && ((r.addr[31:22] ^ aperture_base_in) & aperture_size_in) == 10'h000) begin
			t = UMAD_TGT_DRAM;
			a = {tt[r.addr[21:12]].frame, r.addr[11:0]};
			f = !tt[r.addr[21:12]].valid;
			x = 1'b1;
		end else if (port_active_in && port_command_setting_in[1]
			&& ((mb >= port_window_in.base && mb <= port_window_in.limit)
			|| (mb >= prefetch_window_in.base && mb <= prefetch_window_in.limit))) t = UMAD_TGT_PORT;
		s = t == UMAD_TGT_DRAM && r.initiator != UMAD_INIT_FSB && (r.initiator != UMAD_INIT_AGP || r.cacheable);
		return {t, a, s, x, f, h, r.addr[15:12]};
	endfunction

	// ============================================================
	// tasks
	task automatic check(input string what, input logic [42:0] seen, input logic [42:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic send(input logic [31:0] a, input logic io, input int in);
		umad_req_s r;
		r = '{a, io, umad_init_e'(in), 1'($urandom_range(0, 1))};
		@(posedge clk_in);
		issue <= 1'b1;
		cmd <= r;
		expq.push_back(expect_of(r));
	endtask

	// drain the pipe with a bounded wait, then report the test
	task automatic finish_test(input string name);
		@(posedge clk_in);
		issue <= 1'b0;
		for (int i = 0; i < 16 && expq.size() != 0; i++) @(posedge clk_in);
		if (expq.size() != 0) begin
			errors++;
			final_report();
		end
		$display("test %s done", name);
	endtask

	task automatic do_reset();
		rst_n_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		check("reset valid", 43'(resp_valid_out), 43'h0);
		rst_n_in <= 1'b1;
	endtask

	task automatic corners(input string name);
		foreach (mbs[m]) for (int i = 0; i < 4; i++) begin
			send({mbs[m], (i[0] ? 20'hFFFFF : 20'h00000)}, 1'b0, i);
		end
		send(32'hFEC0_7123, 1'b0, 0);
		foreach (ios[k]) send({16'h0000, ios[k]}, 1'b1, k % 4);
		finish_test(name);
	endtask

	// ============================================================
	// answers compared in order
	always @(posedge clk_in) begin
		if (rst_n_in && resp_valid_out) begin
			exp_now = expq.size() != 0 ? expq.pop_front() : 'x;
			check("response", resp_out, exp_now);
		end
	end

	initial begin
		void'($urandom(32'h1F3B));
		do_reset();
		for (int i = 0; i < 1024; i++) begin
			@(posedge clk_in);
			tt[i] = '{1'($urandom_range(0, 1)), 20'($urandom)};
			tt_wr_en_in <= 1'b1;
			tt_wr_idx_in <= 10'(i);
			tt_wr_entry_in <= tt[i];
		end
		@(posedge clk_in);
		tt_wr_en_in <= 1'b0;
		corners("all windows on");
		port_command_setting_in <= 16'h0000;
		corners("port enables clear");
		{mch_mode_in, gfx_active_in, port_active_in} <= 3'b000;
		port_command_setting_in <= 16'h0003;
		corners("internal claims off");
		{mch_mode_in, gfx_active_in, port_active_in} <= 3'b111;
		do_reset();
		for (int i = 0; i < 400; i++) begin
			if ($urandom_range(0, 3) == 0) begin
				@(posedge clk_in);
				issue <= 1'b0;
			end
			send({mbs[$urandom_range(0, 23)], 20'($urandom)}, 1'b0, $urandom_range(0, 3));
		end
		finish_test("random");
		final_report();
	end
endmodule // test_umad_decoder
`default_nettype wire
